// ==== rtl/pfsm_top.sv ====
// Pin function select matrix with AXI4-Lite register access
// Operation
// - A set option bit routes its peripheral signal onto the terminal.
// - Software chooses which terminal feeds a multi-terminal peripheral input.
// - After reset every selectable input comes from its dedicated terminal.
// - Two-bit selector: dedicated when first bit clear or both set.
// - Two-bit selector: muxed only when first set and second clear.
// - Port B bit 2 uses one bit: clear dedicated, set muxed.
// - Port B bit 2 muxed forces pull disable to zero.
// - Port B bit 2 muxed forces pull select to one (pull-up).
// - Serial port four selector bits stay writable though without effect.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module pfsm_top (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [31:0]                         s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [31:0]                         s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  input  wire logic [pfsm_pkg::NTERM*pfsm_pkg::NOPT-1:0] periph_out_i,
  output logic [pfsm_pkg::NTERM-1:0]               pad_out,
  input  wire logic [pfsm_pkg::NSEL-1:0]           ded_pin,
  input  wire logic [pfsm_pkg::NSEL-1:0]           mux_pin,
  output logic [pfsm_pkg::NSEL-1:0]                sel_periph_in,
  output logic                                     pull_disable_ctl,
  output logic                                     pull_select_field
);

  localparam int unsigned NPIN = 2 * pfsm_pkg::NSEL;

  function automatic logic [31:0] rst_val(input int unsigned i);
    if ((i >= pfsm_pkg::SEL_REG_LO && i <= pfsm_pkg::SEL_REG_HI) ||
        i >= pfsm_pkg::NOUT_REG) begin
      return pfsm_pkg::ZERO_RST;
    end
    return pfsm_pkg::FUNC_RST;
  endfunction : rst_val

  function automatic logic addr_ok(input logic [31:0] a);
    return (a[31:2] < 30'(pfsm_pkg::NREG));
  endfunction : addr_ok

  function automatic logic [pfsm_pkg::IDX_W-1:0] addr_idx(
    input logic [31:0] a);
    return a[pfsm_pkg::IDX_W+1:2];
  endfunction : addr_idx

  // Lowest set option wins, so a double setting still drives one source
  function automatic logic pick(input logic [pfsm_pkg::NOPT-1:0] opt,
                                input logic [pfsm_pkg::NOPT-1:0] src);
    logic r;
    r = src[0];
    for (int k = pfsm_pkg::NOPT - 1; k >= 0; k--) begin
      if (opt[k]) begin
        r = src[k];
      end
    end
    return r;
  endfunction : pick

  // Register file and AXI state
  logic [31:0]               regs_r   [pfsm_pkg::NSTORE];
  logic [31:0]               regs_nxt [pfsm_pkg::NSTORE];
  logic                      aw_hold_r, aw_hold_nxt;
  logic                      w_hold_r, w_hold_nxt;
  logic [31:0]               awaddr_r, awaddr_nxt;
  logic [31:0]               wdata_r, wdata_nxt;
  logic [3:0]                wstrb_r, wstrb_nxt;
  logic                      awready_r, awready_nxt;
  logic                      wready_r, wready_nxt;
  logic                      bvalid_r, bvalid_nxt;
  logic [1:0]                bresp_r, bresp_nxt;
  logic                      arready_r, arready_nxt;
  logic                      rvalid_r, rvalid_nxt;
  logic [31:0]               rdata_r, rdata_nxt;
  logic [1:0]                rresp_r, rresp_nxt;
  logic                      do_wr;
  logic [pfsm_pkg::IDX_W-1:0] wr_idx;
  logic [pfsm_pkg::NSEL-1:0] muxed_c;

  assign do_wr  = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_idx = addr_idx(awaddr_r);

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    regs_nxt    = regs_r;
    if (s_axi_awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = addr_ok(awaddr_r) ? pfsm_pkg::RESP_OKAY
                                      : pfsm_pkg::RESP_SLVERR;
      // Every stored bit is writable, serial four selectors included
      if (addr_ok(awaddr_r) && wr_idx < pfsm_pkg::NSTORE) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_r[b]) begin
            regs_nxt[wr_idx][b*8 +: 8] = wdata_r[b*8 +: 8];
          end
        end
      end
    end
    awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_hold_nxt & ~bvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 32'h0000_0000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= pfsm_pkg::RESP_OKAY;
      for (int i = 0; i < pfsm_pkg::NSTORE; i++) begin
        regs_r[i] <= rst_val(i);
      end
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      regs_r    <= regs_nxt;
    end
  end

  // Read channel; status word shows which selectors take the muxed path
  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = pfsm_pkg::RESP_OKAY;
      rdata_nxt   = 32'h0000_0000;
      if (!addr_ok(s_axi_araddr)) begin
        rresp_nxt = pfsm_pkg::RESP_SLVERR;
      end else if (addr_idx(s_axi_araddr) == pfsm_pkg::STAT_IDX) begin
        rdata_nxt[pfsm_pkg::NSEL-1:0] = muxed_c;
      end else begin
        rdata_nxt = regs_r[addr_idx(s_axi_araddr)];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= pfsm_pkg::RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Pin synchronisers: three stages, change accepted once the second and third stages agree
  logic [NPIN-1:0] s1_r, s2_r, s3_r, filt_r;
  logic [NPIN-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;
  logic [pfsm_pkg::NSEL-1:0] ded_f, mux_f;

  always_comb begin
    s1_nxt   = {mux_pin, ded_pin};
    s2_nxt   = s1_r;
    s3_nxt   = s2_r;
    filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      filt_r <= '0;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      filt_r <= filt_nxt;
    end
  end

  assign ded_f = filt_r[pfsm_pkg::NSEL-1:0];
  assign mux_f = filt_r[NPIN-1:pfsm_pkg::NSEL];

  logic [pfsm_pkg::NSEL-1:0] sel_c;

  for (genvar i = 0; i < pfsm_pkg::NSEL; i++) begin : g_sel
    pfsm_in_sel #(
      .ONE_BIT (i == pfsm_pkg::GPB2_SEL)
    ) u_sel (
      .bit1    (regs_r[pfsm_pkg::SEL_B1_IDX[i]][pfsm_pkg::SEL_B1_BIT[i]]),
      .bit2    (regs_r[pfsm_pkg::SEL_B2_IDX[i]][pfsm_pkg::SEL_B2_BIT[i]]),
      .ded_in  (ded_f[i]),
      .mux_in  (mux_f[i]),
      .muxed   (muxed_c[i]),
      .sel_out (sel_c[i])
    );
  end

  // Output matrix and pull override
  logic [pfsm_pkg::NTERM-1:0] pad_r, pad_nxt;
  logic [pfsm_pkg::NSEL-1:0]  sel_r, sel_nxt;
  logic                       pdis_r, pdis_nxt, psel_r, psel_nxt;
  logic [31:0]                pull_w;

  assign pull_w = regs_r[pfsm_pkg::PULL_IDX];

  always_comb begin
    for (int t = 0; t < pfsm_pkg::NTERM; t++) begin
      pad_nxt[t] = pick(regs_r[t / pfsm_pkg::LANES][(t % 4)*8 +: 6],
                        periph_out_i[t*pfsm_pkg::NOPT +: 6]);
    end
    sel_nxt = sel_c;
    pdis_nxt = pull_w[pfsm_pkg::PULL_DIS_BIT];
    psel_nxt = pull_w[pfsm_pkg::PULL_SEL_BIT];
    if (muxed_c[pfsm_pkg::GPB2_SEL]) begin
      pdis_nxt = 1'b0;
      psel_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_r  <= '0;
      sel_r  <= '0;
      pdis_r <= 1'b0;
      psel_r <= 1'b0;
    end else begin
      pad_r  <= pad_nxt;
      sel_r  <= sel_nxt;
      pdis_r <= pdis_nxt;
      psel_r <= psel_nxt;
    end
  end

  assign pad_out           = pad_r;
  assign sel_periph_in     = sel_r;
  assign pull_disable_ctl  = pdis_r;
  assign pull_select_field = psel_r;

  // Checks
  logic gb_sel, h1_b1, h1_b2;
  assign gb_sel = regs_r[29][16];
  assign h1_b1  = regs_r[20][17];
  assign h1_b2  = regs_r[24][16];

  property p_route_opt;
    @(posedge aclk) disable iff (!aresetn)
    (regs_r[0][1:0] == 2'h2) |=> (pad_out[0] == $past(periph_out_i[1]));
  endproperty
  a_route_opt: assert property (p_route_opt)
    else $error("option two not routed to terminal");

  property p_default_fn;
    @(posedge aclk) disable iff (!aresetn)
    (regs_r[0][5:0] == 6'h00) |=> (pad_out[0] == $past(periph_out_i[0]));
  endproperty
  a_default_fn: assert property (p_default_fn)
    else $error("terminal with no option lost default function");

  property p_reset_ded;
    @(posedge aclk) !aresetn |=> (muxed_c == '0);
  endproperty
  a_reset_ded: assert property (p_reset_ded)
    else $error("selector not dedicated after reset");

  property p_two_ded;
    @(posedge aclk) disable iff (!aresetn)
    (!h1_b1 || h1_b2) |=> (sel_periph_in[1] == $past(ded_f[1]));
  endproperty
  a_two_ded: assert property (p_two_ded)
    else $error("two-bit selector left dedicated path");

  property p_two_mux;
    @(posedge aclk) disable iff (!aresetn)
    (h1_b1 && !h1_b2) |=> (sel_periph_in[1] == $past(mux_f[1]));
  endproperty
  a_two_mux: assert property (p_two_mux)
    else $error("two-bit selector did not take muxed path");

  property p_gb_mux;
    @(posedge aclk) disable iff (!aresetn)
    gb_sel |=> (sel_periph_in[0] == $past(mux_f[0]));
  endproperty
  a_gb_mux: assert property (p_gb_mux)
    else $error("port b bit 2 not fed from muxed terminal");

  property p_pull_dis;
    @(posedge aclk) disable iff (!aresetn)
    gb_sel ##1 gb_sel |-> !pull_disable_ctl;
  endproperty
  a_pull_dis: assert property (p_pull_dis)
    else $error("pull disable not forced low");

  property p_pull_up;
    @(posedge aclk) disable iff (!aresetn)
    gb_sel |=> pull_select_field;
  endproperty
  a_pull_up: assert property (p_pull_up)
    else $error("pull select not forced high");

  property p_s4_keep;
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && addr_ok(awaddr_r) && wstrb_r == 4'hF &&
     wr_idx == 6'(pfsm_pkg::S4_SEL_IDX))
      |=> (regs_r[pfsm_pkg::S4_SEL_IDX] == $past(wdata_r));
  endproperty
  a_s4_keep: assert property (p_s4_keep)
    else $error("serial four selector word not stored");

  c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_gb_mux: cover property (@(posedge aclk) sel_r[0] && gb_sel);
  c_two_mux: cover property (@(posedge aclk) muxed_c[1]);

endmodule : pfsm_top

// ==== rtl/pfsm_pkg.sv ====
// Constants shared by the pin function select matrix
package pfsm_pkg;

  // Register file geometry
  localparam int unsigned NREG       = 42;
  localparam int unsigned NSTORE     = 41;
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned NOUT_REG   = 35;
  localparam int unsigned LANES      = 4;
  localparam int unsigned NTERM      = NOUT_REG * LANES;
  localparam int unsigned NOPT       = 6;
  localparam int unsigned NSEL       = 9;

  // Register indices; byte address is four times the index
  localparam int unsigned SEL_REG_LO = 24;
  localparam int unsigned SEL_REG_HI = 29;
  localparam int unsigned S4_SEL_IDX = 35;
  localparam int unsigned PULL_IDX   = 40;
  localparam int unsigned STAT_IDX   = 41;

  // Field positions
  localparam int unsigned PULL_DIS_BIT = 0;
  localparam int unsigned PULL_SEL_BIT = 1;
  localparam int unsigned S4_SEL_W     = 5;

  // Reset values
  localparam logic [31:0] FUNC_RST = 32'h0101_0101;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Input selectors: entry 0 is port B bit 2, single control bit
  localparam int unsigned GPB2_SEL = 0;
  localparam int unsigned SEL_B1_IDX [NSEL] =
    '{29, 20, 8, 9, 12, 7, 0, 0, 9};
  localparam int unsigned SEL_B1_BIT [NSEL] =
    '{16, 17, 9, 25, 17, 9, 26, 18, 10};
  localparam int unsigned SEL_B2_IDX [NSEL] =
    '{29, 24, 24, 25, 25, 25, 25, 26, 26};
  localparam int unsigned SEL_B2_BIT [NSEL] =
    '{16, 16, 24, 0, 8, 16, 24, 0, 8};

endpackage : pfsm_pkg

// ==== rtl/pfsm_in_sel.sv ====
// Input path selector: dedicated or multiplexed terminal
`timescale 1ns/1ps
module pfsm_in_sel #(
  parameter bit ONE_BIT = 1'b0
) (
  input  wire logic bit1,
  input  wire logic bit2,
  input  wire logic ded_in,
  input  wire logic mux_in,
  output logic      muxed,
  output logic      sel_out
);

  always_comb begin
    if (ONE_BIT) begin
      muxed = bit1;
    end else begin
      muxed = bit1 & ~bit2;
    end
    sel_out = muxed ? mux_in : ded_in;
  end

endmodule : pfsm_in_sel

// ==== test/tb.sv ====
// Self-checking bench for the pin function select matrix
`timescale 1ns/1ps
module tb;
  localparam int NT = pfsm_pkg::NTERM;
  localparam int NS = pfsm_pkg::NSEL;
  logic              aclk          = 1'b0;
  logic              aresetn       = 1'b0;
  logic [31:0]       s_axi_awaddr  = 32'h0;
  logic              s_axi_awvalid = 1'b0;
  logic [31:0]       s_axi_wdata   = 32'h0;
  logic [3:0]        s_axi_wstrb   = 4'h0;
  logic              s_axi_wvalid  = 1'b0;
  logic              s_axi_bready  = 1'b0;
  logic [31:0]       s_axi_araddr  = 32'h0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_rready  = 1'b0;
  logic [NT*6-1:0]   periph_out_i  = '0;
  logic [NS-1:0]     ded_pin       = '0;
  logic [NS-1:0]     mux_pin       = '0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [31:0]       s_axi_rdata;
  logic [NT-1:0]     pad_out;
  logic [NS-1:0]     sel_periph_in;
  logic              pull_disable_ctl, pull_select_field;
  logic [33:0]       rq[$];
  logic [1:0]        wq[$];
  logic [33:0]       rexp;
  logic [1:0]        bexp;
  int                err_count   = 0;
  int                comparisons = 0;
  int                seed, i, e, c, k, l, r, idx;
  logic [31:0]       tmp, v;
  logic [7:0]        lane;
  logic              m;

  pfsm_top u_pfsm_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .periph_out_i(periph_out_i),
    .pad_out(pad_out), .ded_pin(ded_pin), .mux_pin(mux_pin),
    .sel_periph_in(sel_periph_in), .pull_disable_ctl(pull_disable_ctl),
    .pull_select_field(pull_select_field)
  );

  always #2.5 aclk = ~aclk;

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic timeout;
    err_count++;
    $display("[FAIL] bus handshake expected done seen stuck");
    summarize();
  endtask : timeout

  // Response is checked by the monitor when it appears
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] br);
    int n;
    wq.push_back(br);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    s_axi_bready <= 1'b0;
    // One edge with ready low before the next request raises it again
    @(posedge aclk);
    if (n == 100) timeout();
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] rr);
    int n;
    rq.push_back({d, rr});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (n == 100) timeout();
  endtask : axi_read

  task automatic new_pins;
    tmp = $random(seed);
    ded_pin <= tmp[NS-1:0];
    mux_pin <= ~tmp[NS-1:0];
    // Pin path has synchronisers and a filter
    repeat (8) @(posedge aclk);
  endtask : new_pins

  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0) begin
      rexp = rq.pop_front();
      chk("rdata", rexp[33:2], s_axi_rdata);
      chk("rresp", 32'(rexp[1:0]), 32'(s_axi_rresp));
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && wq.size() > 0) begin
      bexp = wq.pop_front();
      chk("bresp", 32'(bexp), 32'(s_axi_bresp));
    end
  end

  initial begin
    seed = 24751;
    for (i = 0; i < NT * 6; i++) begin
      tmp = $random(seed);
      periph_out_i[i] <= tmp[0];
    end
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    new_pins();
    for (i = 0; i < NT; i++)
      chk("pad", 32'(periph_out_i[6*i]), 32'(pad_out[i]));
    chk("sel", 32'(ded_pin), 32'(sel_periph_in));
    for (i = 0; i < 42; i++) begin
      v = (i < 24 || (i >= 30 && i < 35)) ? pfsm_pkg::FUNC_RST
                                          : pfsm_pkg::ZERO_RST;
      axi_read(32'(4 * i), v, pfsm_pkg::RESP_OKAY);
    end
    // Option bits: each single bit, none, then several
    for (c = 0; c < 3; c++) begin
      // Register zero first, the one the matrix assertions watch
      r = (c == 0) ? 0 : {$random(seed)} % 35;
      for (k = 0; k < 8; k++) begin
        lane = k < 6 ? 8'h01 << k : (k == 6 ? 8'h00 : 8'h3C);
        idx = k < 6 ? k : (k == 6 ? 0 : 2);
        axi_write(32'(4 * r), {4{lane}}, 4'hF, pfsm_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        for (l = 0; l < 4; l++)
          chk("pad", 32'(periph_out_i[6*(4*r+l)+idx]),
              32'(pad_out[4*r+l]));
      end
      tmp = $random(seed) & 32'h3F3F_3F3F;
      axi_write(32'(4 * r), tmp, 4'hF, pfsm_pkg::RESP_OKAY);
      axi_write(32'(4 * r), ~tmp, 4'h4, pfsm_pkg::RESP_OKAY);
      // Whole bytes are stored, unused option bits included
      v = (tmp & 32'hFF00_FFFF) | (~tmp & 32'h00FF_0000);
      axi_read(32'(4 * r), v, pfsm_pkg::RESP_OKAY);
      // Clear the word so no selector bit stays set for later scenarios
      axi_write(32'(4 * r), 32'h0000_0000, 4'hF, pfsm_pkg::RESP_OKAY);
    end
    // Two-bit selectors, all four codes each
    for (e = 1; e < NS; e++) begin
      for (c = 0; c < 4; c++) begin
        axi_write(32'(4 * pfsm_pkg::SEL_B1_IDX[e]),
                  c[0] ? 32'h1 << pfsm_pkg::SEL_B1_BIT[e] : 32'h0,
                  4'hF, pfsm_pkg::RESP_OKAY);
        axi_write(32'(4 * pfsm_pkg::SEL_B2_IDX[e]),
                  c[1] ? 32'h1 << pfsm_pkg::SEL_B2_BIT[e] : 32'h0,
                  4'hF, pfsm_pkg::RESP_OKAY);
        m = c[0] & ~c[1];
        new_pins();
        chk("sel", 32'(m ? mux_pin[e] : ded_pin[e]),
            32'(sel_periph_in[e]));
        axi_read(32'(4 * pfsm_pkg::STAT_IDX), 32'(m) << e,
                 pfsm_pkg::RESP_OKAY);
      end
      axi_write(32'(4 * pfsm_pkg::SEL_B1_IDX[e]), 32'h0, 4'hF,
                pfsm_pkg::RESP_OKAY);
    end
    // Port B bit 2: software pull set opposite to the forced values
    axi_write(32'(4 * pfsm_pkg::PULL_IDX), 32'h1, 4'hF, pfsm_pkg::RESP_OKAY);
    axi_write(32'h24, 32'h0, 4'hF, pfsm_pkg::RESP_OKAY);
    axi_write(32'(4 * 29), 32'h1 << 16, 4'hF, pfsm_pkg::RESP_OKAY);
    new_pins();
    chk("sel0", 32'(mux_pin[0]), 32'(sel_periph_in[0]));
    chk("pulldis", 32'h0, 32'(pull_disable_ctl));
    chk("pullsel", 32'h1, 32'(pull_select_field));
    axi_write(32'(4 * 29), 32'h0, 4'hF, pfsm_pkg::RESP_OKAY);
    new_pins();
    chk("sel0", 32'(ded_pin[0]), 32'(sel_periph_in[0]));
    chk("pulldis", 32'h1, 32'(pull_disable_ctl));
    chk("pullsel", 32'h0, 32'(pull_select_field));
    // Serial port four selector bits: stored, no effect on inputs
    axi_write(32'(4 * pfsm_pkg::S4_SEL_IDX), 32'h1F, 4'hF, pfsm_pkg::RESP_OKAY);
    axi_read(32'(4 * pfsm_pkg::S4_SEL_IDX), 32'h1F, pfsm_pkg::RESP_OKAY);
    new_pins();
    chk("sel", 32'(ded_pin), 32'(sel_periph_in));
    // Status is read-only, past the map is an error
    axi_write(32'(4 * pfsm_pkg::STAT_IDX), 32'hFFFF_FFFF, 4'hF, pfsm_pkg::RESP_OKAY);
    axi_read(32'(4 * pfsm_pkg::STAT_IDX), 32'h0, pfsm_pkg::RESP_OKAY);
    axi_write(32'(4 * pfsm_pkg::NREG), 32'hFFFF_FFFF, 4'hF, pfsm_pkg::RESP_SLVERR);
    axi_read(32'(4 * pfsm_pkg::NREG), 32'h0, pfsm_pkg::RESP_SLVERR);
    repeat (4) @(posedge aclk);
    summarize();
  end
endmodule : tb
